// >>> logic/hv_indirect_register_port.sv
// Purpose: Command interpreter reaching four indirect registers over a 2-wire link
// Assumes: Link clock is made by the far end and runs freely; data pin idles high
// Notes:   Frame is a low start bit, command byte, then data byte, MSB first
`timescale 1ns/10ps
`default_nettype none
module hv_indirect_register_port
   import hv_port_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              resetn,
   input  wire logic [BUS_W-1:0]  bus_addr,
   input  wire logic              bus_wr,
   input  wire logic              bus_rd,
   input  wire logic [BUS_W-1:0]  bus_wdata,
   output logic      [BUS_W-1:0]  bus_rdata,
   output logic                   bus_rvalid,
   input  wire logic              link_sclk,
   input  wire logic              link_sdata_in,
   output logic                   link_sdata_out,
   output logic                   link_sdata_oe
);

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SEND,
      ST_RECV
   } link_state_e;

   // Command classification
   function automatic logic is_read_cmd(input logic [CMD_W-1:0] code);
      return (code == CMD_RD_CFG0) || (code == CMD_RD_CFG1) ||
             (code == CMD_RD_STAT) || (code == CMD_RD_MON);
   endfunction

   function automatic logic is_write_cmd(input logic [CMD_W-1:0] code);
      return (code == CMD_WR_CFG0) || (code == CMD_WR_CFG1);
   endfunction

   // Pin synchroniser
   hv_link_if link ();

   hv_pin_sync u_sync (
      .clk_sys   (clk_sys),
      .resetn    (resetn),
      .sclk_pin  (link_sclk),
      .sdata_pin (link_sdata_in),
      .link      (link.producer)
   );

   // Edge detection on the cleaned link clock
   logic sclk_prev;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         sclk_prev <= 1'b1;
      end else begin
         sclk_prev <= link.sclk;
      end
   end

   wire sclk_rise = link.sclk && !sclk_prev;
   wire sclk_fall = !link.sclk && sclk_prev;

   // State
   link_state_e              state;
   link_state_e              next_state;
   logic [CMD_W-1:0]         cmd;
   logic [DATA_W-1:0]        data_port;
   logic [FRAME_W-1:0]       tx_shift;
   logic [BYTE_W-1:0]        rx_shift;
   logic [4:0]               bits_left;
   logic                     busy;
   logic                     tx_ok;
   logic                     rx_ok;
   logic                     timer_expired;

   // Register decode
   wire cmd_sel  = (bus_addr == CMD_PORT_ADDR);
   wire data_sel = (bus_addr == DATA_PORT_ADDR);
   wire [CMD_W-1:0] wr_code = bus_wdata[CMD_W-1:0];
   wire code_read  = is_read_cmd(wr_code);
   wire code_write = is_write_cmd(wr_code);

   // Commands are taken only when idle; unknown codes are ignored
   wire cmd_accept = bus_wr && cmd_sel && !busy && (code_read || code_write);
   wire data_write = bus_wr && data_sel && !busy;
   wire cur_read   = is_read_cmd(cmd);

   // Transfer end conditions
   wire send_last  = (state == ST_SEND) && sclk_fall && (bits_left == 5'd0);
   wire send_bit   = (state == ST_SEND) && sclk_fall && (bits_left != 5'd0);
   wire recv_bit   = (state == ST_RECV) && sclk_rise;
   wire recv_last  = recv_bit && (bits_left == 5'd1);
   wire write_done = send_last && !cur_read;
   wire turnaround = send_last && cur_read;
   // Frame still unfinished when the latency window from accept runs out
   wire abort      = busy && timer_expired;
   wire finish     = write_done || recv_last || abort;

   // Bounds every frame; a silent far end ends it as a failure
   hv_latency_timer u_timer (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .start   (cmd_accept),
      .stop    (write_done || recv_last),
      .expired (timer_expired)
   );

   // Frame contents for the accepted command
   wire [FRAME_W-1:0] frame_load =
      {1'b0, wr_code, data_port[DATA_LSB +: BYTE_W]};
   wire [4:0] frame_bits = code_read ? READ_FRAME_BITS : WRITE_FRAME_BITS;
   // One spare rise after turnaround: our own last command bit is still
   // on the wire at the first one, so it is shifted in and pushed out
   wire [4:0] recv_bits = READ_BACK_BITS + 5'd1;

   // Next state
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (cmd_accept) begin
               next_state = ST_SEND;
            end
         end
         ST_SEND: begin
            if (timer_expired || write_done) begin
               next_state = ST_IDLE;
            end else if (turnaround) begin
               next_state = ST_RECV;
            end
         end
         ST_RECV: begin
            if (timer_expired || recv_last) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Busy flag
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         busy <= 1'b0;
      end else if (cmd_accept) begin
         busy <= 1'b1;
      end else if (finish) begin
         busy <= 1'b0;
      end
   end

   // Latched command code
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cmd <= CMD_RESET;
      end else if (cmd_accept) begin
         cmd <= wr_code;
      end
   end

   // Bit counter
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         bits_left <= 5'd0;
      end else if (cmd_accept) begin
         bits_left <= frame_bits;
      end else if (turnaround) begin
         bits_left <= recv_bits;
      end else if (finish) begin
         bits_left <= 5'd0;
      end else if (send_bit || recv_bit) begin
         bits_left <= bits_left - 5'd1;
      end
   end

   // Outgoing shift register and pin drive, changed on link clock falls
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         tx_shift <= '0;
      end else if (cmd_accept) begin
         tx_shift <= frame_load;
      end else if (finish) begin
         tx_shift <= '0;
      end else if (send_bit) begin
         tx_shift <= {tx_shift[FRAME_W-2:0], 1'b0};
      end
   end

   // Data pin released high between frames
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         link_sdata_out <= 1'b1;
         link_sdata_oe  <= 1'b0;
      end else if (finish || turnaround) begin
         link_sdata_out <= 1'b1;
         link_sdata_oe  <= 1'b0;
      end else if (send_bit) begin
         link_sdata_out <= tx_shift[FRAME_W-1];
         link_sdata_oe  <= 1'b1;
      end
   end

   // Incoming shift register, sampled on link clock rises
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rx_shift <= '0;
      end else if (cmd_accept) begin
         rx_shift <= '0;
      end else if (recv_bit) begin
         rx_shift <= {rx_shift[BYTE_W-2:0], link.sdata};
      end
   end

   // Outcome flags, cleared at accept, set on completion
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         tx_ok <= 1'b0;
      end else if (cmd_accept) begin
         tx_ok <= 1'b0;
      end else if (write_done || turnaround) begin
         tx_ok <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rx_ok <= 1'b0;
      end else if (cmd_accept) begin
         rx_ok <= 1'b0;
      end else if (recv_last) begin
         rx_ok <= 1'b1;
      end
   end

   // Data port: software writes the byte; tag and read-back come from hardware
   wire [BYTE_W-1:0] read_byte = {rx_shift[BYTE_W-2:0], link.sdata};
   wire [TAG_W-1:0]  cmd_tag   = wr_code[TAG_W-1:0];

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         data_port <= DATA_RESET;
      end else if (recv_last) begin
         data_port[DATA_LSB +: BYTE_W] <= read_byte;
      end else if (cmd_accept) begin
         data_port[TAG_LSB +: TAG_W] <= cmd_tag;
      end else if (data_write) begin
         data_port[DATA_LSB +: BYTE_W] <= bus_wdata[DATA_LSB +: BYTE_W];
      end
   end

   // Read path: only the two ports are visible; others read as zero
   wire [BUS_W-1:0] cmd_read_word =
      {{(BUS_W-3){1'b0}}, tx_ok, rx_ok, busy};
   wire [BUS_W-1:0] data_read_word =
      {{(BUS_W-DATA_W){1'b0}}, data_port};
   wire [BUS_W-1:0] read_word =
      cmd_sel  ? cmd_read_word  :
      data_sel ? data_read_word : '0;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         bus_rdata  <= '0;
         bus_rvalid <= 1'b0;
      end else begin
         bus_rvalid <= bus_rd;
         if (bus_rd) begin
            bus_rdata <= read_word;
         end
      end
   end

endmodule
`default_nettype wire

// >>> logic/hv_port_pkg.sv
// Purpose: Shared constants for the high voltage indirect register port
// Assumes: 20 MHz system clock, byte-wide commands, 12-bit data register
// Notes:   Timing counts derive from the time figures and the clock period
package hv_port_pkg;

   // Memory-mapped register addresses
   localparam logic [31:0] CMD_PORT_ADDR  = 32'hFFFF_0804;
   localparam logic [31:0] DATA_PORT_ADDR = 32'hFFFF_080C;

   // Widths
   localparam int CMD_W   = 8;
   localparam int DATA_W  = 12;
   localparam int BYTE_W  = 8;
   localparam int TAG_W   = 4;
   localparam int BUS_W   = 32;
   localparam int FRAME_W = 17;

   // Command codes
   localparam logic [7:0] CMD_RD_CFG0 = 8'h00;
   localparam logic [7:0] CMD_RD_CFG1 = 8'h01;
   localparam logic [7:0] CMD_RD_STAT = 8'h02;
   localparam logic [7:0] CMD_RD_MON  = 8'h03;
   localparam logic [7:0] CMD_WR_CFG0 = 8'h08;
   localparam logic [7:0] CMD_WR_CFG1 = 8'h09;

   // Command port read fields
   localparam int BUSY_BIT  = 0;
   localparam int RX_OK_BIT = 1;
   localparam int TX_OK_BIT = 2;

   // Data port fields
   localparam int DATA_LSB = 0;
   localparam int TAG_LSB  = 8;

   // Frame lengths in link bits: start bit, command, optional data byte
   localparam logic [4:0] WRITE_FRAME_BITS = 5'd17;
   localparam logic [4:0] READ_FRAME_BITS  = 5'd9;
   localparam logic [4:0] READ_BACK_BITS   = 5'd8;

   // Reset values
   localparam logic [11:0] DATA_RESET = 12'h000;
   localparam logic [7:0]  CMD_RESET  = 8'h00;

   // Timing
   localparam int SYS_PERIOD_NS  = 50;
   localparam int LATENCY_MAX_NS = 10000;
   localparam int LATENCY_CYCLES = (LATENCY_MAX_NS / SYS_PERIOD_NS < 1) ? 1 :
                                   LATENCY_MAX_NS / SYS_PERIOD_NS;
   localparam int TIMER_W        = 8;

endpackage

// >>> logic/hv_link_if.sv
// Purpose: Cleaned link levels passed from the pin synchroniser to the core
// Assumes: Both ends run on clk_sys
// Notes:   Levels only; edges are found by the consumer
`timescale 1ns/10ps
`default_nettype none
interface hv_link_if;
   logic sclk;
   logic sdata;

   modport producer (output sclk, output sdata);
   modport consumer (input sclk, input sdata);
endinterface
`default_nettype wire

// >>> logic/hv_pin_sync.sv
// Purpose: Bring the link clock and data pins into the clk_sys domain
// Assumes: Pins are asynchronous to clk_sys
// Notes:   Three stages; a level counts once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module hv_pin_sync (
   input  wire logic clk_sys,
   input  wire logic resetn,
   input  wire logic sclk_pin,
   input  wire logic sdata_pin,
   hv_link_if.producer link
);

   logic [1:0] stage1;
   logic [1:0] stage2;
   logic [1:0] stage3;
   logic [1:0] level;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         stage1 <= 2'b11;
         stage2 <= 2'b11;
         stage3 <= 2'b11;
      end else begin
         stage1 <= {sclk_pin, sdata_pin};
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // Accept a bit only when the last two stages agree
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         level <= 2'b11;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (stage2[i] == stage3[i]) begin
               level[i] <= stage3[i];
            end
         end
      end
   end

   assign link.sclk  = level[1];
   assign link.sdata = level[0];

endmodule
`default_nettype wire

// >>> logic/hv_latency_timer.sv
// Purpose: Bounds each link transfer to the documented latency
// Assumes: start is a one-cycle pulse
// Notes:   expired pulses once, LATENCY_CYCLES cycles after start
`timescale 1ns/10ps
`default_nettype none
module hv_latency_timer
   import hv_port_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic resetn,
   input  wire logic start,
   input  wire logic stop,
   output logic      expired
);

   localparam logic [TIMER_W-1:0] LOAD = TIMER_W'(LATENCY_CYCLES);

   logic [TIMER_W-1:0] count;
   logic               running;
   wire                last_tick = running && (count == TIMER_W'(1));

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         count   <= '0;
         running <= 1'b0;
         expired <= 1'b0;
      end else begin
         expired <= last_tick && !stop && !start;
         if (start) begin
            count   <= LOAD;
            running <= 1'b1;
         end else if (stop || last_tick) begin
            running <= 1'b0;
         end else if (running) begin
            count <= count - TIMER_W'(1);
         end
      end
   end

endmodule
`default_nettype wire

// >>> verification/hv_port_chk.sv
// Purpose: Port-level assertions for the indirect register port
// Assumes: Sees only the top module ports
// Notes:   Busy is seen only through command port reads
`timescale 1ns/10ps
`default_nettype none
module hv_port_chk
   import hv_port_pkg::*;
(
   input wire logic             clk_sys,
   input wire logic             resetn,
   input wire logic [BUS_W-1:0] bus_addr,
   input wire logic             bus_wr,
   input wire logic             bus_rd,
   input wire logic [BUS_W-1:0] bus_wdata,
   input wire logic [BUS_W-1:0] bus_rdata,
   input wire logic             bus_rvalid,
   input wire logic             link_sclk,
   input wire logic             link_sdata_in,
   input wire logic             link_sdata_out,
   input wire logic             link_sdata_oe
);
   localparam int LAT = LATENCY_CYCLES;
   logic [8:0] oe_len;
   wire        rd_cmd  = bus_rd && bus_addr == CMD_PORT_ADDR;
   wire        rd_dat  = bus_rd && bus_addr == DATA_PORT_ADDR;
   wire        rd_none = bus_rd && !rd_cmd && !rd_dat;

   // Length of the current driven stretch of the data pin
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         oe_len <= 9'h000;
      end else begin
         oe_len <= link_sdata_oe ? oe_len + 9'h001 : 9'h000;
      end
   end

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   a_rvalid_pulse: assert property (bus_rd |=> bus_rvalid)
      else $error("read answer missing");
   a_rvalid_only: assert property (!bus_rd |=> !bus_rvalid)
      else $error("read answer without a read");
   a_rdata_hold: assert property (!bus_rd |=> $stable(bus_rdata))
      else $error("read data changed without a read");
   a_unmapped_zero: assert property (rd_none |=> bus_rdata == '0)
      else $error("unmapped address read nonzero");
   a_cmd_reserved: assert property (rd_cmd |=> bus_rdata[31:3] == '0)
      else $error("command port reserved bits set");
   a_data_width: assert property (rd_dat |=> bus_rdata[31:12] == '0)
      else $error("data port wider than twelve bits");
   a_busy_drive: assert property (rd_cmd && link_sdata_oe |=> bus_rdata[BUSY_BIT])
      else $error("busy low while frame is driven");
   a_idle_level: assert property (!link_sdata_oe |-> link_sdata_out)
      else $error("data pin not released high");
   a_start_low: assert property ($rose(link_sdata_oe) |-> !link_sdata_out)
      else $error("frame does not open with a low bit");
   a_frame_bound: assert property (oe_len <= LAT)
      else $error("frame driven beyond latency bound");

   c_frame: cover property ($rose(link_sdata_oe));
   c_tx_ok: cover property (rd_cmd ##1 bus_rdata[2:0] == 3'h4);
   c_rx_ok: cover property (rd_cmd ##1 bus_rdata[2:0] == 3'h6);
endmodule

bind hv_indirect_register_port hv_port_chk u_chk (
   .clk_sys(clk_sys), .resetn(resetn), .bus_addr(bus_addr), .bus_wr(bus_wr),
   .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
   .link_sclk(link_sclk), .link_sdata_in(link_sdata_in),
   .link_sdata_out(link_sdata_out), .link_sdata_oe(link_sdata_oe)
);
`default_nettype wire

// >>> verification/hv_far_end.sv
// Purpose: Behavioural model of the indirect registers across the link
// Assumes: Link clock runs free while run is high, stands low otherwise
// Notes:   Data line has a pull-up when nobody drives it
`timescale 1ns/10ps
`default_nettype none
module hv_far_end #(
   parameter logic [7:0] STAT_VAL = 8'h96,
   parameter logic [7:0] MON_VAL  = 8'h3C
) (
   input  wire logic       run,
   input  wire logic       sdata_out,
   input  wire logic       sdata_oe,
   output logic            sclk,
   output logic            sdata,
   output logic [7:0]      cfg0,
   output logic [7:0]      cfg1
);
   logic [7:0] cmd;
   logic [7:0] dat;
   logic [7:0] sh;
   logic       drv;
   int         cnt;
   int         nr;
   wire  [7:0] sel = cmd[1] ? (cmd[0] ? MON_VAL : STAT_VAL) : (cmd[0] ? cfg1 : cfg0);

   assign sdata = sdata_oe ? sdata_out : (drv ? sh[7] : 1'b1);

   initial begin
      cfg0 = 8'h00;
      cfg1 = 8'h00;
      cmd = 8'h00;
      drv = 1'b0;
      cnt = 0;
      sclk = 1'b0;
      #13;
      forever begin
         #200;
         sclk = run ? ~sclk : 1'b0;
      end
   end

   // Sample on rising link clock, answer on falling
   always @(sclk) begin
      if (sclk) begin
         if (cnt == 0) begin
            cnt <= (sdata == 1'b0) ? 1 : 0;
         end else if (cnt <= 8) begin
            cmd <= {cmd[6:0], sdata};
            cnt <= cnt + 1;
         end else if (cmd[3]) begin
            dat <= {dat[6:0], sdata};
            cnt <= (cnt == 16) ? 0 : cnt + 1;
            if (cnt == 16 && cmd[0]) begin
               cfg1 <= {dat[6:0], sdata};
            end else if (cnt == 16) begin
               cfg0 <= {dat[6:0], sdata};
            end
         end else if (drv) begin
            nr <= nr + 1;
         end
      end else if (cnt == 9 && !cmd[3] && !drv) begin
         sh <= sel;
         drv <= 1'b1;
         nr <= 0;
      end else if (drv && nr == 8) begin
         drv <= 1'b0;
         cnt <= 0;
      end else if (drv) begin
         sh <= {sh[6:0], 1'b0};
      end
   end
endmodule
`default_nettype wire

// >>> verification/tb.sv
// Purpose: Self-checking bench for the indirect register port
// Assumes: Inputs change on falling clk_sys
// Notes:   Link clock stopped once to force a transfer failure
`timescale 1ns/10ps
`default_nettype none
module tb
   import hv_port_pkg::*;
;
   logic        clk_sys = 1'b0;
   logic        resetn;
   logic        bus_wr;
   logic        bus_rd;
   logic        run;
   logic        rvalid;
   logic        sd_out;
   logic        sd_oe;
   logic        sclk;
   logic        sdata;
   logic [31:0] bus_addr;
   logic [31:0] bus_wdata;
   logic [31:0] rdata;
   logic [31:0] rd;
   logic [7:0]  cfg0;
   logic [7:0]  cfg1;
   logic [7:0]  exp_rd [4] = '{8'h5A, 8'hC3, 8'h96, 8'h3C};
   int          fails = 0;
   int          n_checks = 0;

   always #25 clk_sys = ~clk_sys;

   hv_indirect_register_port uut (
      .clk_sys(clk_sys), .resetn(resetn), .bus_addr(bus_addr), .bus_wr(bus_wr),
      .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(rdata), .bus_rvalid(rvalid),
      .link_sclk(sclk), .link_sdata_in(sdata), .link_sdata_out(sd_out), .link_sdata_oe(sd_oe)
   );
   hv_far_end u_far (
      .run(run), .sdata_out(sd_out), .sdata_oe(sd_oe), .sclk(sclk), .sdata(sdata),
      .cfg0(cfg0), .cfg1(cfg1)
   );

   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(negedge clk_sys);
      bus_addr = a;
      bus_wdata = d;
      bus_wr = 1'b1;
      @(negedge clk_sys);
      bus_wr = 1'b0;
   endtask

   task automatic rd_reg(input logic [31:0] a, output logic [31:0] d);
      @(negedge clk_sys);
      bus_addr = a;
      bus_rd = 1'b1;
      @(negedge clk_sys);
      bus_rd = 1'b0;
      check("rvalid", 32'(rvalid), 32'h0000_0001);
      d = rdata;
   endtask

   task automatic wait_idle(output int n);
      n = 0;
      do begin
         rd_reg(CMD_PORT_ADDR, rd);
         n += 2;
      end while (rd[BUSY_BIT] !== 1'b0 && n < 600);
      if (n >= 600) begin
         fails++;
         $display("[ERR] busy never cleared");
         stop_test();
      end
   endtask

   task automatic run_cmd(input logic [7:0] code, input logic [2:0] flags);
      int n;
      wr(CMD_PORT_ADDR, {24'h00_0000, code});
      rd_reg(CMD_PORT_ADDR, rd);
      check("busy", 32'(rd[BUSY_BIT]), 32'h0000_0001);
      wait_idle(n);
      check("latency", 32'(n <= LATENCY_CYCLES + 4), 32'h0000_0001);
      rd_reg(CMD_PORT_ADDR, rd);
      check("flags", rd, {29'h0000_0000, flags});
   endtask

   initial begin
      resetn = 1'b0;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      bus_addr = 32'h0000_0000;
      bus_wdata = 32'h0000_0000;
      run = 1'b1;
      repeat (20) @(negedge clk_sys);
      resetn = 1'b1;
      rd_reg(CMD_PORT_ADDR, rd);
      check("cmd reset", rd, 32'h0000_0000);
      rd_reg(DATA_PORT_ADDR, rd);
      check("data reset", rd, 32'h0000_0000);
      wr(32'hFFFF_0808, 32'h0000_0008);
      rd_reg(32'hFFFF_0808, rd);
      check("unmapped", rd, 32'h0000_0000);
      rd_reg(CMD_PORT_ADDR, rd);
      check("idle", rd, 32'h0000_0000);
      $display("test reset done");
      for (int i = 0; i < 2; i++) begin
         wr(DATA_PORT_ADDR, {24'h00_0F00 >> 8, exp_rd[i]} | 32'h0000_0F00);
         run_cmd(8'h08 + 8'(i), 3'h4);
         rd_reg(DATA_PORT_ADDR, rd);
         check("data tag", rd, {20'h0_0000, 4'(8 + i), exp_rd[i]});
      end
      check("cfg0", 32'(cfg0), 32'h0000_005A);
      check("cfg1", 32'(cfg1), 32'h0000_00C3);
      $display("test writes done");
      for (int c = 0; c < 4; c++) begin
         run_cmd(8'(c), 3'h6);
         rd_reg(DATA_PORT_ADDR, rd);
         check("read back", rd, {20'h0_0000, 4'(c), exp_rd[c]});
      end
      $display("test reads done");
      wr(CMD_PORT_ADDR, 32'h0000_0005);
      rd_reg(CMD_PORT_ADDR, rd);
      check("bad code", rd, 32'h0000_0006);
      wr(DATA_PORT_ADDR, 32'h0000_0077);
      wr(CMD_PORT_ADDR, 32'h0000_0008);
      wr(CMD_PORT_ADDR, 32'h0000_0001);
      wr(DATA_PORT_ADDR, 32'h0000_0011);
      run_cmd(8'h05, 3'h4);
      rd_reg(DATA_PORT_ADDR, rd);
      check("busy refusal", rd, 32'h0000_0877);
      check("cfg0 busy", 32'(cfg0), 32'h0000_0077);
      $display("test busy done");
      run = 1'b0;
      repeat (10) @(negedge clk_sys);
      run_cmd(8'h09, 3'h0);
      check("cfg1 kept", 32'(cfg1), 32'h0000_00C3);
      run = 1'b1;
      run_cmd(8'h01, 3'h6);
      rd_reg(DATA_PORT_ADDR, rd);
      check("recovered", rd, 32'h0000_01C3);
      $display("test failure done");
      stop_test();
   end
endmodule
`default_nettype wire
